// ==== pmrs_pkg.sv ====
// Package with constants and types for the power mode and reset sequencer.
package pmrs_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h1;
    localparam logic [3:0] ADDR_WAKEUP  = 4'h2;

    // Control register field positions.
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int CTRL_PDOWN_BIT = 1;
    localparam int CTRL_MAINOSC_BIT = 2;

    // Status register field positions.
    localparam int ST_BOD_BIT   = 0;
    localparam int ST_FLASH_BIT = 1;
    localparam int ST_MODE_LSB  = 2;

    // Wake-up cycle counts.
    localparam logic [12:0] IRC_WAKE_CYCLES  = 13'h0004;
    localparam logic [12:0] MAIN_WAKE_CYCLES = 13'h1000;

    // Oscillator and flash start-up times, RC and system clock periods, in nanoseconds.
    localparam int IRC_STARTUP_NS   = 60000;
    localparam int FLASH_STARTUP_NS = 100000;
    localparam int IRC_PERIOD_NS    = 250;
    localparam int CLK_PERIOD_NS    = 8;

    // Cycle counts derived from the times above, least times rounded up.
    localparam int IRC_STARTUP_CYC = (IRC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLASH_IRC_CYC   = (FLASH_STARTUP_NS + IRC_PERIOD_NS - 1) / IRC_PERIOD_NS;

    // Fixed count of clocks held in reset after all sources release.
    localparam logic [7:0] RESET_HOLD_CYCLES = 8'h40;

    // Address where the processor starts after reset.
    localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;

    // Sequencer states.
    typedef enum logic [5:0] {
        ST_RESET = 6'b000001,
        ST_RUN   = 6'b000010,
        ST_SLEEP = 6'b000100,
        ST_PDOWN = 6'b001000,
        ST_OSCUP = 6'b010000,
        ST_WAKE  = 6'b100000
    } pmrs_state_t;

    // Clock and power gating controls sent to clock generation.
    typedef struct packed {
        logic core_clk_en;
        logic irc_out_en;
        logic irc_power;
        logic rtc_osc_en;
        logic main_osc_en;
        logic pll_power;
        logic pll_connect;
        logic flash_power;
        logic flash_access_en;
        logic pin_hold;
        logic div_clear;
        logic use_irc;
    } pmrs_clkctl_t;

endpackage

// ==== pmrs_seq.sv ====
// Power mode, wake-up timing, reset merging and brown-out sequencer.
// Operation
// - Sleep entry stops oscillator and gates all internal clocks.
// - Sleep keeps state, SRAM and freezes pin output levels.
// - Sleep disables internal RC output but keeps it powered.
// - Real-time-clock oscillator keeps running in Sleep for wake-up.
// - Sleep entry powers down and disconnects the PLL.
// - Sleep entry clears core and USB clock dividers to zero.
// - Sleep exits only on reset or a clockless wake interrupt.
// - Flash stays powered during Sleep.
// - Wake from Sleep on internal RC resumes after 4 cycles.
// - Wake from Sleep on main oscillator resumes after 4096 cycles.
// - Power-down does all Sleep actions and also stops RC and flash.
// - Power-down wake waits RC start-up, then 4 RC cycles.
// - Flash wake counter counts RC cycles over flash start-up time.
// - Flash accesses blocked until flash wake counter expires.
// - Chip reset merges pin, dog timer, power-on and brown-out.
// - Reset held until pin released, oscillator up, count done, flash ready.
// - After reset release the processor fetches from address zero.
// - All registers hold reset values when internal reset releases.
// - First brown-out threshold raises interrupt request to controller.
// - First-stage brown-out condition readable in a status register.
// - Second threshold asserts reset until power-on reset takes over.
// - After reset or Power-down exit run on RC with PLL bypassed.
module pmrs_seq
    import pmrs_pkg::*;
(
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    input  wire logic        EXT_RESET_I,
    input  wire logic        DOG_TIMER_RESET_I,
    input  wire logic        POWER_ON_RESET_I,
    input  wire logic        BOD_STAGE1_I,
    input  wire logic        BOD_STAGE2_I,
    input  wire logic        OSC_RUNNING_I,
    input  wire logic        FLASH_INIT_DONE_I,
    input  wire logic        IRC_TICK_I,
    input  wire logic        WAKE_IRQ_I,
    input  wire logic [3:0]  REG_ADDR_I,
    input  wire logic [31:0] REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic [31:0]      REG_RDATA_O,
    output logic             CHIP_RESET_O,
    output logic [31:0]      BOOT_ADDR_O,
    output logic             BOD_IRQ_O,
    output pmrs_clkctl_t     CLKCTL_O
);

    // Sequencer state and counters.
    pmrs_state_t   state_ff;
    pmrs_state_t   nxt_state;
    logic [12:0]   wake_cnt_ff;
    logic [15:0]   osc_cnt_ff;
    logic [15:0]   flash_cnt_ff;
    logic [7:0]    hold_cnt_ff;
    logic          main_src_ff;
    logic          from_pdown_ff;
    logic          flash_ready_ff;
    logic [1:0]    rst_sync_ff;
    logic          req_sleep;
    logic          req_pdown;
    logic          reset_src;

    localparam logic [15:0] IRC_STARTUP_CNT = 16'(IRC_STARTUP_CYC);
    localparam logic [15:0] FLASH_CNT       = 16'(FLASH_IRC_CYC);

    // Any of the four sources, brown-out stage two included, resets the chip.
    assign reset_src = EXT_RESET_I | DOG_TIMER_RESET_I | POWER_ON_RESET_I | BOD_STAGE2_I;

    // Only a write to the control register can request a low-power mode.
    assign req_sleep = REG_WR_I && (REG_ADDR_I == ADDR_CTRL) && REG_WDATA_I[CTRL_SLEEP_BIT];
    assign req_pdown = REG_WR_I && (REG_ADDR_I == ADDR_CTRL) && REG_WDATA_I[CTRL_PDOWN_BIT];

    // Release of the merged source is synchronised so reset drops on an edge.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            rst_sync_ff <= 2'h3;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], reset_src};
        end
    end

    // State transitions.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RESET: begin
                // Hold until pin released, oscillator up, clocks counted, flash ready.
                if (!rst_sync_ff[1] && OSC_RUNNING_I && FLASH_INIT_DONE_I &&
                    hold_cnt_ff == RESET_HOLD_CYCLES) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (req_pdown) begin
                    nxt_state = ST_PDOWN;
                end else if (req_sleep) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (WAKE_IRQ_I) begin
                    nxt_state = ST_WAKE;
                end
            end
            ST_PDOWN: begin
                if (WAKE_IRQ_I) begin
                    nxt_state = ST_OSCUP;
                end
            end
            ST_OSCUP: begin
                if (osc_cnt_ff == IRC_STARTUP_CNT) begin
                    nxt_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wake_cnt_ff == (main_src_ff ? MAIN_WAKE_CYCLES : IRC_WAKE_CYCLES)) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RESET;
            end
        endcase
        if (rst_sync_ff[1]) begin
            nxt_state = ST_RESET;
        end
    end

    // State register.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            state_ff <= ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Fixed reset hold count restarts while any source is active.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            hold_cnt_ff <= 8'h00;
        end else if (state_ff != ST_RESET || rst_sync_ff[1] || !OSC_RUNNING_I) begin
            hold_cnt_ff <= 8'h00;
        end else if (hold_cnt_ff != RESET_HOLD_CYCLES) begin
            hold_cnt_ff <= hold_cnt_ff + 8'h01;
        end
    end

    // Mode and clock source captured at entry pick the wake count later.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            main_src_ff   <= 1'b0;
            from_pdown_ff <= 1'b0;
        end else if (state_ff == ST_RESET) begin
            main_src_ff   <= 1'b0;
            from_pdown_ff <= 1'b0;
        end else if (state_ff == ST_RUN && (req_sleep || req_pdown)) begin
            // Power-down restarts on the RC, so its wake always uses the short count.
            main_src_ff   <= REG_WDATA_I[CTRL_MAINOSC_BIT] && !req_pdown;
            from_pdown_ff <= req_pdown;
        end
    end

    // Oscillator start-up counter runs on the system clock after Power-down wake.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            osc_cnt_ff <= 16'h0000;
        end else if (state_ff == ST_OSCUP) begin
            osc_cnt_ff <= osc_cnt_ff + 16'h0001;
        end else begin
            osc_cnt_ff <= 16'h0000;
        end
    end

    // Wake counter counts RC ticks or system cycles for the main oscillator.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            wake_cnt_ff <= 13'h0000;
        end else if (state_ff != ST_WAKE) begin
            wake_cnt_ff <= 13'h0000;
        end else if (main_src_ff || IRC_TICK_I) begin
            wake_cnt_ff <= wake_cnt_ff + 13'h0001;
        end
    end

    // Flash wake counter counts RC ticks after leaving Power-down; flash
    // access stays blocked until it expires, even if code already runs.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            flash_cnt_ff   <= 16'h0000;
            flash_ready_ff <= 1'b0;
        end else if (state_ff == ST_RESET) begin
            flash_cnt_ff   <= 16'h0000;
            flash_ready_ff <= FLASH_INIT_DONE_I;
        end else if (state_ff == ST_PDOWN) begin
            flash_cnt_ff   <= 16'h0000;
            flash_ready_ff <= 1'b0;
        end else if (!flash_ready_ff && state_ff != ST_SLEEP) begin
            // Outside reset the flag is only low after Power-down, so a Sleep entered
            // before the count expires must not strand the flash in the blocked state.
            if (flash_cnt_ff == FLASH_CNT) begin
                flash_ready_ff <= 1'b1;
            end else if (IRC_TICK_I) begin
                flash_cnt_ff <= flash_cnt_ff + 16'h0001;
            end
        end
    end

    // Clock, oscillator, PLL and flash controls follow the state.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            CLKCTL_O <= '0;
        end else begin
            CLKCTL_O.rtc_osc_en      <= 1'b1;
            CLKCTL_O.use_irc         <= (nxt_state == ST_RESET) || !main_src_ff;
            CLKCTL_O.pll_power       <= 1'b0;
            CLKCTL_O.pll_connect     <= 1'b0;
            CLKCTL_O.flash_access_en <= flash_ready_ff && nxt_state == ST_RUN;
            unique case (nxt_state)
                ST_SLEEP: begin
                    CLKCTL_O.core_clk_en <= 1'b0;
                    CLKCTL_O.main_osc_en <= 1'b0;
                    CLKCTL_O.irc_out_en  <= 1'b0;
                    CLKCTL_O.irc_power   <= 1'b1;
                    CLKCTL_O.flash_power <= 1'b1;
                    CLKCTL_O.pin_hold    <= 1'b1;
                    CLKCTL_O.div_clear   <= 1'b1;
                end
                ST_PDOWN: begin
                    CLKCTL_O.core_clk_en <= 1'b0;
                    CLKCTL_O.main_osc_en <= 1'b0;
                    CLKCTL_O.irc_out_en  <= 1'b0;
                    CLKCTL_O.irc_power   <= 1'b0;
                    CLKCTL_O.flash_power <= 1'b0;
                    CLKCTL_O.pin_hold    <= 1'b1;
                    CLKCTL_O.div_clear   <= 1'b1;
                end
                ST_OSCUP, ST_WAKE: begin
                    CLKCTL_O.core_clk_en <= 1'b0;
                    CLKCTL_O.main_osc_en <= main_src_ff;
                    CLKCTL_O.irc_out_en  <= 1'b1;
                    CLKCTL_O.irc_power   <= 1'b1;
                    CLKCTL_O.flash_power <= 1'b1;
                    CLKCTL_O.pin_hold    <= 1'b1;
                    CLKCTL_O.div_clear   <= 1'b0;
                end
                default: begin
                    CLKCTL_O.core_clk_en <= (nxt_state == ST_RUN);
                    CLKCTL_O.main_osc_en <= main_src_ff;
                    CLKCTL_O.irc_out_en  <= 1'b1;
                    CLKCTL_O.irc_power   <= 1'b1;
                    CLKCTL_O.flash_power <= 1'b1;
                    CLKCTL_O.pin_hold    <= 1'b0;
                    CLKCTL_O.div_clear   <= (nxt_state == ST_RESET);
                end
            endcase
        end
    end

    // Chip reset and boot address; the reset vector is fixed at address zero.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            CHIP_RESET_O <= 1'b1;
            BOOT_ADDR_O  <= RESET_VECTOR;
        end else begin
            CHIP_RESET_O <= (nxt_state == ST_RESET);
            BOOT_ADDR_O  <= RESET_VECTOR;
        end
    end

    // Brown-out stage one goes to the interrupt controller as a level.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            BOD_IRQ_O <= 1'b0;
        end else begin
            BOD_IRQ_O <= BOD_STAGE1_I;
        end
    end

    // Read data stand one cycle after the read strobe and are zero otherwise.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            REG_RDATA_O <= 32'h0000_0000;
        end else if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                ADDR_CTRL: begin
                    REG_RDATA_O <= 32'({main_src_ff, from_pdown_ff, 1'b0}) << 0;
                end
                ADDR_STATUS: begin
                    REG_RDATA_O <= 32'({state_ff, flash_ready_ff, BOD_STAGE1_I});
                end
                ADDR_WAKEUP: begin
                    REG_RDATA_O <= 32'(wake_cnt_ff);
                end
                default: begin
                    REG_RDATA_O <= 32'h0000_0000;
                end
            endcase
        end else begin
            REG_RDATA_O <= 32'h0000_0000;
        end
    end

endmodule

// ==== pmrs_seq_asserts.sv ====
// Port checker for the power mode and reset sequencer.
module pmrs_seq_asserts
    import pmrs_pkg::*;
(
    input wire logic         CLK_SYS_I,
    input wire logic         RST_I,
    input wire logic         EXT_RESET_I,
    input wire logic         DOG_TIMER_RESET_I,
    input wire logic         POWER_ON_RESET_I,
    input wire logic         BOD_STAGE1_I,
    input wire logic         BOD_STAGE2_I,
    input wire logic         OSC_RUNNING_I,
    input wire logic         FLASH_INIT_DONE_I,
    input wire logic [3:0]   REG_ADDR_I,
    input wire logic [31:0]  REG_WDATA_I,
    input wire logic         REG_WR_I,
    input wire logic         REG_RD_I,
    input wire logic [31:0]  REG_RDATA_O,
    input wire logic         CHIP_RESET_O,
    input wire logic [31:0]  BOOT_ADDR_O,
    input wire logic         BOD_IRQ_O,
    input wire pmrs_clkctl_t CLKCTL_O
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RST_I);

    // Any reset source, the conditions the hold count runs under, and a mode write while running.
    // Flash readiness is not part of the count; it is checked on its own when reset drops.
    logic       src_on;
    logic       all_ok;
    logic       run_wr;
    logic [7:0] ok_cnt_ff;
    assign src_on = EXT_RESET_I | DOG_TIMER_RESET_I | POWER_ON_RESET_I | BOD_STAGE2_I;
    assign all_ok = !src_on && OSC_RUNNING_I;
    assign run_wr = REG_WR_I && REG_ADDR_I == ADDR_CTRL && CLKCTL_O.core_clk_en && !CHIP_RESET_O;

    // Cycles since the release conditions last broke; saturates so it never wraps.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ok_cnt_ff <= 8'h00;
        end else if (!all_ok) begin
            ok_cnt_ff <= 8'h00;
        end else if (ok_cnt_ff != 8'hFF) begin
            ok_cnt_ff <= ok_cnt_ff + 8'h01;
        end
    end

    chk_sleep_gate: assert property (run_wr && REG_WDATA_I[1:0] == 2'b01 |=>
        !CLKCTL_O.core_clk_en && !CLKCTL_O.pll_power && !CLKCTL_O.pll_connect
        && CLKCTL_O.div_clear && CLKCTL_O.pin_hold) else $error("sleep gating wrong");
    chk_sleep_keep: assert property (run_wr && REG_WDATA_I[1:0] == 2'b01 |=>
        CLKCTL_O.irc_power && !CLKCTL_O.irc_out_en && CLKCTL_O.rtc_osc_en
        && CLKCTL_O.flash_power) else $error("sleep keeps wrong parts");
    chk_pdown_off: assert property (run_wr && REG_WDATA_I[1] |=>
        !CLKCTL_O.irc_power && !CLKCTL_O.flash_power && !CLKCTL_O.core_clk_en
        && CLKCTL_O.rtc_osc_en) else $error("power-down controls wrong");
    chk_flash_block: assert property (!CLKCTL_O.flash_power |-> !CLKCTL_O.flash_access_en)
        else $error("flash access while unpowered");
    chk_reset_merge: assert property (src_on [*4] |-> CHIP_RESET_O)
        else $error("reset source not merged");
    chk_reset_hold: assert property ($fell(CHIP_RESET_O) |-> ok_cnt_ff >= RESET_HOLD_CYCLES
        && $past(FLASH_INIT_DONE_I)) else $error("reset released early");
    chk_boot_vec: assert property ($fell(CHIP_RESET_O) |-> BOOT_ADDR_O == RESET_VECTOR
        && CLKCTL_O.use_irc && !CLKCTL_O.pll_power && !CLKCTL_O.pll_connect)
        else $error("state after reset wrong");
    chk_bod_irq: assert property (BOD_STAGE1_I ##1 BOD_STAGE1_I |-> BOD_IRQ_O)
        else $error("brown-out request missing");
    chk_bod_status: assert property (REG_RD_I && REG_ADDR_I == ADDR_STATUS && BOD_IRQ_O
        && BOD_STAGE1_I |=> REG_RDATA_O[ST_BOD_BIT]) else $error("brown-out status missing");

    cover property (run_wr && REG_WDATA_I[1:0] == 2'b01);
    cover property (run_wr && REG_WDATA_I[1]);
    cover property ($fell(CHIP_RESET_O));
endmodule

bind pmrs_seq pmrs_seq_asserts u_chk (
    .CLK_SYS_I, .RST_I, .EXT_RESET_I, .DOG_TIMER_RESET_I, .POWER_ON_RESET_I,
    .BOD_STAGE1_I, .BOD_STAGE2_I, .OSC_RUNNING_I, .FLASH_INIT_DONE_I, .REG_ADDR_I,
    .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .CHIP_RESET_O, .BOOT_ADDR_O,
    .BOD_IRQ_O, .CLKCTL_O
);

// ==== pmrs_clkgen_model.sv ====
// Behavioural clock generator and flash controller facing the sequencer.
module pmrs_clkgen_model
    import pmrs_pkg::*;
#(
    parameter int TICK_DIV = 31
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire pmrs_clkctl_t clkctl_i,
    output logic              osc_running_o,
    output logic              flash_done_o,
    output logic              irc_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int up_cnt;
    int div_cnt;

    // The oscillator settles a few clocks after power-up, the flash set-up a few more.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_cnt <= 0;
        end else if (up_cnt < 15) begin
            up_cnt <= up_cnt + 1;
        end
    end
    assign osc_running_o = up_cnt >= 4;
    assign flash_done_o = up_cnt >= 8;

    // One tick per RC period and none while the RC is unpowered, so wake counts stall there.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i || !clkctl_i.irc_power) begin
            div_cnt <= 0;
            irc_tick_o <= 1'b0;
        end else begin
            div_cnt <= (div_cnt >= TICK_DIV - 1) ? 0 : div_cnt + 1;
            irc_tick_o <= div_cnt == TICK_DIV - 1;
        end
    end
endmodule

// ==== tb_pmrs_seq.sv ====
// Self-checking bench for the power mode and reset sequencer.
module tb_pmrs_seq
    import pmrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk, rst, ext, dog, por, bod1, bod2, osc, fdone, tick, wake, wr, rd;
    logic         chip_rst, bod_irq;
    logic [3:0]   addr;
    logic [31:0]  wdata, rdata, boot, d;
    pmrs_clkctl_t ctl;
    int           err_total, total_checks, n;

    // Free-running 125 MHz clock.
    always #4 clk = ~clk;

    pmrs_seq dut_u (
        .CLK_SYS_I(clk), .RST_I(rst), .EXT_RESET_I(ext), .DOG_TIMER_RESET_I(dog),
        .POWER_ON_RESET_I(por), .BOD_STAGE1_I(bod1), .BOD_STAGE2_I(bod2),
        .OSC_RUNNING_I(osc), .FLASH_INIT_DONE_I(fdone), .IRC_TICK_I(tick),
        .WAKE_IRQ_I(wake), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .CHIP_RESET_O(chip_rst), .BOOT_ADDR_O(boot),
        .BOD_IRQ_O(bod_irq), .CLKCTL_O(ctl)
    );
    pmrs_clkgen_model far_u (
        .clk_i(clk), .rst_i(rst), .clkctl_i(ctl), .osc_running_o(osc),
        .flash_done_o(fdone), .irc_tick_o(tick)
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just after that edge.
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    function automatic logic seen(input int k);
        case (k)
            0: return ctl.core_clk_en;
            1: return !chip_rst;
            default: return ctl.flash_access_en;
        endcase
    endfunction

    // Counts edges until the chosen condition holds; a bound keeps a stuck design from hanging.
    task automatic wait_on(input int k, input int lim, output int cnt);
        cnt = 0;
        while (seen(k) !== 1'b1 && cnt < lim) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        check("wait bound", 32'h1, 32'(cnt < lim));
    endtask

    task automatic wake_up(input int lim);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        #1;
        wait_on(0, lim, n);
    endtask

    // All tests take some 17000 cycles; this limit leaves ample margin.
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        end_of_test();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {ext, dog, por, bod1, bod2, wake, wr, rd} = 8'h00;
        addr = 4'h0;
        wdata = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1;
        wait_on(1, 300, n);
        check("reset hold", 32'h1, 32'(n >= 64));
        check("boot addr", RESET_VECTOR, boot);
        check("reset clk", 32'h1, 32'(ctl.use_irc && !ctl.pll_power && !ctl.pll_connect));
        rd_reg(ADDR_STATUS, d);
        check("status run", {24'h0, ST_RUN, 2'b10}, d);
        rd_reg(ADDR_CTRL, d);
        check("ctrl reset", 32'h0, d);
        rd_reg(4'hF, d);
        check("unmapped", 32'h0, d);
        $display("test reset done");
        // Sleep on the RC clock; a mode write while asleep must be ignored.
        wr_reg(ADDR_CTRL, 32'h1);
        d = 32'({ctl.core_clk_en, ctl.irc_out_en, ctl.irc_power, ctl.rtc_osc_en,
                 ctl.pll_power, ctl.pll_connect, ctl.flash_power, ctl.pin_hold, ctl.div_clear});
        check("sleep ctl", 32'h67, d);
        wr_reg(ADDR_CTRL, 32'h2);
        repeat (40) @(posedge clk);
        #1;
        check("sleep hold", 32'h2, 32'({ctl.core_clk_en, ctl.irc_power, 1'b0}));
        rd_reg(ADDR_STATUS, d);
        check("status sleep", 32'(ST_SLEEP), 32'(d[7:2]));
        wake_up(400);
        check("rc wake", 32'h1, 32'(n > 90 && n < 135));
        $display("test sleep rc done");
        wr_reg(ADDR_CTRL, 32'h5);
        // Wake by hand so the running wake count can be read one cycle into the wait.
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        #1;
        rd_reg(ADDR_WAKEUP, d);
        check("wake count", 32'h1, d);
        wait_on(0, 5000, n);
        check("main wake", 32'h1, 32'(n >= 4088 && n <= 4100));
        check("main osc", 32'h1, 32'(ctl.main_osc_en && !ctl.use_irc && !ctl.pll_power));
        rd_reg(ADDR_CTRL, d);
        check("ctrl main", 32'h4, d);
        $display("test sleep main done");
        // Both mode bits set: power-down takes precedence.
        wr_reg(ADDR_CTRL, 32'h3);
        check("pdown ctl", 32'h0, 32'({ctl.irc_power, ctl.flash_power, ctl.flash_access_en}));
        rd_reg(ADDR_STATUS, d);
        check("status pdown", {24'h0, ST_PDOWN, 2'b00}, d);
        wake_up(9000);
        check("pdown wake", 32'h1, 32'(n >= 7500 && ctl.use_irc && !ctl.flash_access_en));
        wait_on(2, 15000, n);
        check("flash delay", 32'h1, 32'(n + 7500 >= 12000));
        rd_reg(ADDR_STATUS, d);
        check("flash ready", 32'h1, 32'(d[ST_FLASH_BIT]));
        rd_reg(ADDR_CTRL, d);
        check("ctrl pdown", 32'h2, d);
        $display("test power-down done");
        @(posedge clk);
        bod1 <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("bod irq", 32'h1, 32'(bod_irq));
        rd_reg(ADDR_STATUS, d);
        check("bod status", 32'h1, 32'(d[ST_BOD_BIT]));
        bod1 <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {ext, dog, por, bod2} <= 4'(4'h8 >> i);
            repeat (4) @(posedge clk);
            #1;
            check("src reset", 32'h1, 32'(chip_rst));
            @(posedge clk);
            {ext, dog, por, bod2} <= 4'h0;
            #1;
            wait_on(1, 300, n);
            check("src release", 32'h1, 32'(n >= 64));
        end
        $display("test brown-out and sources done");
        end_of_test();
    end
endmodule
